// >>> src/lwic_defines.vh
// Summary of operation
// - The timer edge/prescale control register sits at offset 05h, its bits 7..1 are read/write and reset to zero, bit 0 reads zero.
// - Bit 7 picks the edge of the external interrupt pin that sets its flag, 1 rising and 0 falling.
// - Bits 4..1 pick the prescale ratio, 1:1 doubling up to 1:128 for codes 0..7, and 1:256 for any code with the top bit set.
// - A table write to internal program memory starts a long write that halts instruction execution until it ends.
// - Only a reset or an interrupt source ends a long write, never elapsed time.
// - A source ends the long write only when its enable and flag are both set, and the global disable only governs vectoring.
// - When a core source ends the long write, the flag of the highest-priority enabled core source is cleared.
// - If an enabled core interrupt is already pending at the table write, no write happens and that flag is cleared.
// - A peripheral source that ends the long write keeps its flag set.
// - With the global disable clear before the long write, the core branches to the vector when it ends.
// - With the global disable set before the long write, the long write ends without a branch.
`ifndef LWIC_DEFINES_VH
`define LWIC_DEFINES_VH
`define LWIC_ADDR_TEPC      8'h05
`define LWIC_ADDR_IRQ_STAT  8'h20
`define LWIC_ADDR_IRQ_EN    8'h21
`define LWIC_ADDR_IRQ_CLR   8'h22
`define LWIC_ADDR_SRC_EN    8'h23
`define LWIC_ADDR_SRC_FLAG  8'h24
`define LWIC_TEPC_RESET     8'h00
`define LWIC_TEPC_MASK      8'hfe
`define LWIC_PS_FULL        8'hff
`define LWIC_SRC_EN_RESET   4'h0
`define LWIC_FLAG_RESET     3'h0
`define LWIC_EV_RESET       3'h0
`define LWIC_EV_EN_RESET    3'h0
`define LWIC_BIT_EXT_EDGE   7
`define LWIC_BIT_PIN_EDGE   6
`define LWIC_BIT_CLK_SRC    5
`define LWIC_PS_HI          4
`define LWIC_PS_LO          1
`define LWIC_SRC_EXT        0
`define LWIC_SRC_TMR        1
`define LWIC_SRC_PIN        2
`define LWIC_SRC_PERI       3
`define LWIC_EV_START       0
`define LWIC_EV_END         1
`define LWIC_EV_ABORT       2
`endif

// >>> src/lwic_top.v
`include "lwic_defines.vh"

module lwic_top (
  // Clock and reset
  input  wire       clk,
  input  wire       rst_n,
  // Register port
  input  wire [7:0] reg_addr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_wr,
  input  wire       reg_rd,
  output reg  [7:0] reg_rdata,
  // Core sequencer
  input  wire       table_write_instr,
  input  wire       tbl_internal,
  input  wire       global_irq_disable,
  output reg        exec_halt,
  output reg        program_pulse,
  output reg        lw_done,
  output reg        lw_vector,
  output reg        tw_nop,
  // Interrupt sources
  input  wire       ext_irq_pin,
  input  wire       timer_clock_pin,
  input  wire       tmr_overflow,
  input  wire       peri_irq,
  // Timer facing outputs
  output reg        prescale_tick,
  output reg        timer_clock_source_select,
  // Interrupt
  output reg        irq
);

  localparam ST_IDLE = 1'b0;
  localparam ST_LONG = 1'b1;

  reg        state_r;
  reg [7:0]  tepc_r;
  reg [3:0]  src_en_r;
  reg [2:0]  src_flag_r;
  reg        gid_r;
  reg [2:0]  ev_stat_r;
  reg [2:0]  ev_en_r;
  reg [7:0]  ps_cnt_r;
  reg [7:0]  ps_lim;
  reg [2:0]  clr_sel;
  reg [2:0]  flag_nxt;
  reg [2:0]  ev_nxt;

  wire       ext_rise;
  wire       ext_fall;
  wire       ckp_rise;
  wire       ckp_fall;
  wire       ext_edge;
  wire       ckp_edge;
  wire       ps_src;
  wire [3:0] ps_code;
  wire [2:0] core_act;
  wire       peri_act;
  wire       any_act;
  wire       wr_tepc;
  wire       wr_en;
  wire       wr_clr;
  wire       wr_sen;
  wire       wr_sfl;
  wire       tw_go;
  wire       tw_abort;
  wire       tw_start;
  wire       lw_end;

  // Edge detection on the external interrupt pin
  lwic_edge_det #(
    .IDLE_LVL (1'b0)
  ) u_ext_edge (
    .clk   (clk),
    .rst_n (rst_n),
    .pin   (ext_irq_pin),
    .rise  (ext_rise),
    .fall  (ext_fall)
  );

  // Edge detection on the timer clock pin
  lwic_edge_det #(
    .IDLE_LVL (1'b0)
  ) u_ckp_edge (
    .clk   (clk),
    .rst_n (rst_n),
    .pin   (timer_clock_pin),
    .rise  (ckp_rise),
    .fall  (ckp_fall)
  );

  assign ext_edge = tepc_r[`LWIC_BIT_EXT_EDGE] ? ext_rise : ext_fall;
  assign ckp_edge = tepc_r[`LWIC_BIT_PIN_EDGE] ? ckp_fall : ckp_rise;
  assign ps_src   = tepc_r[`LWIC_BIT_CLK_SRC] ? 1'b1 : ckp_edge;

  assign ps_code  = tepc_r[`LWIC_PS_HI:`LWIC_PS_LO];
  always @* begin
    ps_lim = `LWIC_PS_FULL;
    case (ps_code)
      4'h0: begin
        ps_lim = 8'h00;
      end
      4'h1: begin
        ps_lim = 8'h01;
      end
      4'h2: begin
        ps_lim = 8'h03;
      end
      4'h3: begin
        ps_lim = 8'h07;
      end
      4'h4: begin
        ps_lim = 8'h0f;
      end
      4'h5: begin
        ps_lim = 8'h1f;
      end
      4'h6: begin
        ps_lim = 8'h3f;
      end
      4'h7: begin
        ps_lim = 8'h7f;
      end
      default: begin
        ps_lim = `LWIC_PS_FULL;
      end
    endcase
  end

  assign core_act = src_en_r[2:0] & src_flag_r;
  assign peri_act = src_en_r[`LWIC_SRC_PERI] & peri_irq;
  assign any_act  = (|core_act) | peri_act;

  always @* begin
    clr_sel = 3'h0;
    if (core_act[`LWIC_SRC_EXT]) begin
      clr_sel = 3'h1;
    end else if (core_act[`LWIC_SRC_TMR]) begin
      clr_sel = 3'h2;
    end else if (core_act[`LWIC_SRC_PIN]) begin
      clr_sel = 3'h4;
    end
  end

  // Register port write decode
  assign wr_tepc  = reg_wr && (reg_addr == `LWIC_ADDR_TEPC);
  assign wr_en    = reg_wr && (reg_addr == `LWIC_ADDR_IRQ_EN);
  assign wr_clr   = reg_wr && (reg_addr == `LWIC_ADDR_IRQ_CLR);
  assign wr_sen   = reg_wr && (reg_addr == `LWIC_ADDR_SRC_EN);
  assign wr_sfl   = reg_wr && (reg_addr == `LWIC_ADDR_SRC_FLAG);

  assign tw_go    = table_write_instr && tbl_internal && (state_r == ST_IDLE);
  assign tw_abort = tw_go && (|core_act);
  assign tw_start = tw_go && !(|core_act);
  // only an active source ends it
  assign lw_end   = (state_r == ST_LONG) && any_act;

  // Core flag and event status next values
  always @* begin
    flag_nxt = src_flag_r;
    if (wr_sfl) begin
      flag_nxt = reg_wdata[2:0];
    end
    if (tw_abort || (lw_end && (|core_act))) begin
      flag_nxt = flag_nxt & ~clr_sel;
    end
    if (ext_edge) begin
      flag_nxt[`LWIC_SRC_EXT] = 1'b1;
    end
    // Timer overflow sets its flag
    if (tmr_overflow) begin
      flag_nxt[`LWIC_SRC_TMR] = 1'b1;
    end
    if (ckp_edge) begin
      flag_nxt[`LWIC_SRC_PIN] = 1'b1;
    end
    ev_nxt = ev_stat_r;
    if (wr_clr) begin
      ev_nxt = ev_nxt & ~reg_wdata[2:0];
    end
    // Set wins over a clear in the same cycle
    ev_nxt = ev_nxt | {tw_abort, lw_end, tw_start};
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tepc_r <= `LWIC_TEPC_RESET;
    end else begin
      if (wr_tepc) begin
        tepc_r <= reg_wdata & `LWIC_TEPC_MASK;
      end
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      timer_clock_source_select <= 1'b0;
    end else begin
      timer_clock_source_select <= tepc_r[`LWIC_BIT_CLK_SRC];
    end
  end

  // Source and event enables
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ev_en_r  <= `LWIC_EV_EN_RESET;
      src_en_r <= `LWIC_SRC_EN_RESET;
    end else begin
      if (wr_en) begin
        ev_en_r <= reg_wdata[2:0];
      end
      if (wr_sen) begin
        src_en_r <= reg_wdata[3:0];
      end
    end
  end

  // Core flags, event status and interrupt line
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      src_flag_r <= `LWIC_FLAG_RESET;
      ev_stat_r  <= `LWIC_EV_RESET;
      irq        <= 1'b0;
    end else begin
      src_flag_r <= flag_nxt;
      ev_stat_r  <= ev_nxt;
      irq        <= |(ev_nxt & ev_en_r);
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ps_cnt_r      <= 8'h00;
      prescale_tick <= 1'b0;
    end else begin
      prescale_tick <= 1'b0;
      if (ps_src) begin
        if (ps_cnt_r >= ps_lim) begin
          ps_cnt_r      <= 8'h00;
          prescale_tick <= 1'b1;
        end else begin
          ps_cnt_r <= ps_cnt_r + 8'h01;
        end
      end
    end
  end

  // Long write sequencer
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r       <= ST_IDLE;
      gid_r         <= 1'b0;
      exec_halt     <= 1'b0;
      program_pulse <= 1'b0;
      lw_done       <= 1'b0;
      lw_vector     <= 1'b0;
      tw_nop        <= 1'b0;
    end else begin
      lw_done   <= 1'b0;
      lw_vector <= 1'b0;
      tw_nop    <= tw_abort;
      case (state_r)
        ST_IDLE: begin
          if (tw_start) begin
            state_r       <= ST_LONG;
            gid_r         <= global_irq_disable;
            exec_halt     <= 1'b1;
            program_pulse <= 1'b1;
          end
        end
        ST_LONG: begin
          if (lw_end) begin
            state_r       <= ST_IDLE;
            exec_halt     <= 1'b0;
            program_pulse <= 1'b0;
            lw_done       <= 1'b1;
            lw_vector     <= ~gid_r;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // Read data stands one cycle after the strobe
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= 8'h00;
      if (reg_rd) begin
        if (reg_addr == `LWIC_ADDR_TEPC) begin
          reg_rdata <= tepc_r;
        end else if (reg_addr == `LWIC_ADDR_IRQ_STAT) begin
          reg_rdata <= {5'h00, ev_stat_r};
        end else if (reg_addr == `LWIC_ADDR_IRQ_EN) begin
          reg_rdata <= {5'h00, ev_en_r};
        end else if (reg_addr == `LWIC_ADDR_SRC_EN) begin
          reg_rdata <= {4'h0, src_en_r};
        end else if (reg_addr == `LWIC_ADDR_SRC_FLAG) begin
          reg_rdata <= {5'h00, src_flag_r};
        end
      end
    end
  end

endmodule // lwic_top

module lwic_edge_det #(
  parameter IDLE_LVL = 1'b0
) (
  // Clock and reset
  input  wire clk,
  input  wire rst_n,
  // Sampled pin
  input  wire pin,
  // Edge strobes
  output wire rise,
  output wire fall
);

  reg pin_d_r;

  // Reset to the idle level so no false edge follows reset
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_d_r <= IDLE_LVL;
    end else begin
      pin_d_r <= pin;
    end
  end

  assign rise = pin & ~pin_d_r;
  assign fall = ~pin & pin_d_r;

endmodule // lwic_edge_det

// >>> dv/lwic_core_model.sv
module lwic_core_model (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Bench requests
  input  wire logic go,
  input  wire logic gd_in,
  // Block side
  input  wire logic halt,
  output logic      tw,
  output logic      tint,
  output logic      gd
);
  timeunit 1ns;
  timeprecision 1ps;
  assign tint = 1'b1;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tw <= 1'b0;
      gd <= 1'b0;
    end else begin
      tw <= go && !halt;
      if (go) gd <= gd_in;
    end
  end
endmodule // lwic_core_model

// >>> dv/lwic_checker.sv
module lwic_checker (
  // Clock and reset
  input wire       clk,
  input wire       rst_n,
  // Register port
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire       reg_wr,
  input wire       reg_rd,
  input wire [7:0] reg_rdata,
  // Core side
  input wire       table_write_instr,
  input wire       tbl_internal,
  input wire       exec_halt,
  input wire       program_pulse,
  input wire       lw_done,
  input wire       lw_vector,
  input wire       tw_nop,
  input wire       timer_clock_source_select
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_halt_prog: assert property (program_pulse == exec_halt)
    else $error("program pulse differs from halt");
  a_halt_cause: assert property ($rose(exec_halt) |-> $past(table_write_instr && tbl_internal))
    else $error("halt without table write");
  a_done_ends: assert property (lw_done |-> !exec_halt && $past(exec_halt))
    else $error("done not at end of halt");
  a_done_pulse: assert property (lw_done |=> !lw_done)
    else $error("done longer than one cycle");
  a_vec_done: assert property (lw_vector |-> lw_done)
    else $error("vector without done");
  a_nop_idle: assert property (tw_nop |-> !exec_halt && !$past(exec_halt))
    else $error("abort during long write");
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside read slot");
  a_src_copy: assert property (reg_wr && reg_addr == 8'h05 |-> ##2
    timer_clock_source_select == $past(reg_wdata[5], 2))
    else $error("clock source select not updated");
endmodule // lwic_checker
bind lwic_top lwic_checker chk_i (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .table_write_instr, .tbl_internal, .exec_halt, .program_pulse, .lw_done, .lw_vector, .tw_nop,
  .timer_clock_source_select);

// >>> dv/lwic_top_tb.sv
module lwic_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk, rst_n, reg_wr, reg_rd, go, gdv, tw, tint, gd;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic       ext, tpin, tovf, peri, halt, done, vec, nop, tick, csel, irq;
  int         err_count, n_checks, cyc, n;
  lwic_top dut (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .table_write_instr(tw), .tbl_internal(tint), .global_irq_disable(gd), .exec_halt(halt),
    .program_pulse(), .lw_done(done), .lw_vector(vec), .tw_nop(nop), .ext_irq_pin(ext),
    .timer_clock_pin(tpin), .tmr_overflow(tovf), .peri_irq(peri), .prescale_tick(tick),
    .timer_clock_source_select(csel), .irq);
  lwic_core_model core (.clk, .rst_n, .go, .gd_in(gdv), .halt, .tw, .tint, .gd);
  task end_sim;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task chk(input logic [15:0] g, input logic [15:0] e);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("unexpected at %0t got %h exp %h", $time, g, e);
    end
  endtask
  task chkb(input logic g, input logic e);
    chk({15'h0, g}, {15'h0, e});
  endtask
  task idle(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk({8'h00, reg_rdata}, {8'h00, e});
  endtask
  task tws(input logic g);
    @(posedge clk);
    go <= 1'b1;
    gdv <= g;
    @(posedge clk);
    go <= 1'b0;
    idle(1);
  endtask
  task pins(input logic [1:0] v);
    @(posedge clk);
    {tpin, ext} <= v;
    idle(2);
  endtask
  task ovf;
    @(posedge clk);
    tovf <= 1'b1;
    @(posedge clk);
    tovf <= 1'b0;
  endtask
  task wdone(input logic v);
    int i;
    i = 0;
    while (done !== 1'b1 && i < 50) begin
      idle(1);
      i++;
    end
    chkb(done, 1'b1);
    chkb(vec, v);
    chkb(halt, 1'b0);
  endtask
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      end_sim;
    end
  end
  initial begin
    {reg_wr, reg_rd, go, gdv, ext, tpin, tovf, peri, rst_n} = '0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rd(8'h05, 8'h00);
    wr(8'h05, 8'hff);
    rd(8'h05, 8'hfe);
    rd(8'h30, 8'h00);
    chkb(csel, 1'b1);
    for (int c = 0; c < 16; c++) begin
      wr(8'h05, 8'h20 | 8'(c << 1));
      repeat (256) @(posedge clk);
      n = 0;
      repeat (512) begin
        idle(1);
        n += int'(tick);
      end
      chk(16'(n), 16'(c > 7 ? 2 : 512 >> c));
    end
    wr(8'h05, 8'h80);
    idle(1);
    chkb(csel, 1'b0);
    pins(2'b11);
    rd(8'h24, 8'h05);
    wr(8'h24, 8'h00);
    pins(2'b00);
    rd(8'h24, 8'h00);
    wr(8'h05, 8'h40);
    pins(2'b11);
    rd(8'h24, 8'h00);
    pins(2'b00);
    rd(8'h24, 8'h05);
    @(posedge clk);
    tpin <= 1'b1;
    idle(1);
    chkb(tick, 1'b0);
    @(posedge clk);
    tpin <= 1'b0;
    idle(1);
    chkb(tick, 1'b1);
    wr(8'h24, 8'h00);
    wr(8'h23, 8'h03);
    tws(1'b0);
    chkb(halt, 1'b1);
    idle(40);
    chkb(halt, 1'b1);
    ovf;
    wdone(1'b1);
    rd(8'h24, 8'h00);
    wr(8'h23, 8'h00);
    tws(1'b1);
    ovf;
    idle(5);
    chkb(halt, 1'b1);
    wr(8'h23, 8'h02);
    wdone(1'b0);
    rd(8'h24, 8'h00);
    wr(8'h23, 8'h03);
    wr(8'h24, 8'h03);
    tws(1'b0);
    chkb(nop, 1'b1);
    chkb(halt, 1'b0);
    rd(8'h24, 8'h02);
    wr(8'h24, 8'h00);
    wr(8'h23, 8'h08);
    tws(1'b0);
    @(posedge clk);
    peri <= 1'b1;
    wdone(1'b1);
    @(posedge clk);
    peri <= 1'b0;
    rd(8'h20, 8'h07);
    chkb(irq, 1'b0);
    wr(8'h21, 8'h04);
    idle(2);
    chkb(irq, 1'b1);
    wr(8'h22, 8'h04);
    idle(2);
    chkb(irq, 1'b0);
    rd(8'h20, 8'h03);
    wr(8'h05, 8'hfe);
    idle(3);
    @(posedge clk);
    rst_n <= 1'b0;
    @(posedge clk);
    rst_n <= 1'b1;
    rd(8'h05, 8'h00);
    end_sim;
  end
endmodule // lwic_top_tb
